// *** rtl/tccc_pkg.sv ***
// package: shared constants and types for the type-c cc supervisor
package tccc_pkg;
    // time to clock-cycle conversion
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TCC_TIME_US = 150;
    localparam int TCC_CYCLES = (TCC_TIME_US * 1000000) / CLK_PERIOD_PS;
    localparam int VCONN_SHUTOFF_TIME_NS = 8;
    localparam int VCONN_SHUTOFF_CYCLES = (VCONN_SHUTOFF_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int CC_OVP_SHUTOFF_TIME_NS = 8;
    localparam int CC_OVP_SHUTOFF_CYCLES = (CC_OVP_SHUTOFF_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int TCC_CNT_W = 24;

    // per-line termination class
    typedef enum logic [1:0] {
        TCCC_TERM_OPEN = 2'h0,
        TCCC_TERM_RD = 2'h1,
        TCCC_TERM_RA = 2'h2
    } tccc_term_e;

    // comparator reference selection
    localparam logic [1:0] REF_SRC_LOW = 2'h0;
    localparam logic [1:0] REF_SRC_HIGH = 2'h1;
    localparam logic [1:0] REF_SNK = 2'h2;

    // sink-side decoded advertised current
    localparam logic [1:0] ADV_NONE = 2'h0;
    localparam logic [1:0] ADV_DEFAULT = 2'h1;
    localparam logic [1:0] ADV_LOW = 2'h2;
    localparam logic [1:0] ADV_HIGH = 2'h3;

    // one-hot attach states
    typedef enum logic [6:0] {
        TCCC_ST_OPEN = 7'h01,
        TCCC_ST_SNK_1 = 7'h02,
        TCCC_ST_SNK_2 = 7'h04,
        TCCC_ST_CBL_1 = 7'h08,
        TCCC_ST_CBL_2 = 7'h10,
        TCCC_ST_FULL_1 = 7'h20,
        TCCC_ST_FULL_2 = 7'h40
    } tccc_state_e;

    // comparator levels seen on one cc line
    typedef struct packed {
        logic below_cable_marker;
        logic below_attach;
        logic above_disc_default;
        logic above_disc_high;
        logic snk_low;
        logic snk_high;
        logic ovp;
        logic squelch;
    } tccc_cc_cmp_s;

    // port control outputs
    typedef struct packed {
        logic bus_power_en;
        logic vconn_first_en;
        logic vconn_second_en;
        logic watch_first;
        logic watch_second;
        logic tx_en;
        logic tx_on_second;
    } tccc_ctrl_s;
endpackage

// *** rtl/tccc_supervisor.sv ***
// module: per-port type-c cc attach, orientation and vconn supervisor
`timescale 1ns/10ps
// Functional notes
// - both open: nothing attached, all power off
// - rd first only: sink, bus power, watch first
// - rd second only: sink, bus power, watch second
// - ra first only: cable, no power, watch both
// - ra second only: cable, no power, watch both
// - ra first rd second: vconn first, watch second
// - rd first ra second: vconn second, watch first
// - low pull-up until regulator settled at 5 v
// - below cable marker threshold means ra cable
// - disconnect after tcc above selected threshold
// - comparator reference follows role and pull-up current
// - sink: pulldown, attach on bus, decode current
// - vconn overtemperature in limit: shut off, flag recovery
// - regulator undervoltage disables both vconn paths
// - cc overvoltage disables vconn and pd transmitter
// - squelch follows the cc line state
// - only one transmitter; idle drivers high impedance
// - communicate on the mated cc line; cable-only states use the first line
module tccc_supervisor
    import tccc_pkg::*;
#(
    parameter int TCC_CNT = TCC_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic sink_role_i,
    input wire logic pullup_high_req_i,
    input wire logic regulator_settled_i,
    input wire logic bus_present_i,
    input wire tccc_cc_cmp_s cc_first_i,
    input wire tccc_cc_cmp_s cc_second_i,
    input wire logic vconn_limit_i,
    input wire logic vconn_overtemp_i,
    input wire logic rail_uvlo_i,
    input wire logic reverse_current_i,
    input wire logic tx_req_i,
    input wire logic tx_data_i,
    input wire logic error_recovery_ack_i,
    output tccc_state_e attach_state_o,
    output tccc_ctrl_s ctrl_o,
    output logic pullup_high_o,
    output logic [1:0] cmp_ref_o,
    output logic sink_pulldown_o,
    output logic sink_attached_o,
    output logic [1:0] sink_adv_current_o,
    output logic error_recovery_o,
    output logic squelch_o,
    output logic cc_first_out_o,
    output logic cc_first_oe_n_o,
    output logic cc_second_out_o,
    output logic cc_second_oe_n_o
);

    // ======================================================================
    // helpers
    // ======================================================================

    // classify a cc line from its comparators
    function automatic tccc_term_e classify(input tccc_cc_cmp_s c);
        if (c.below_cable_marker) begin
            classify = TCCC_TERM_RA;
        end else if (c.below_attach) begin
            classify = TCCC_TERM_RD;
        end else begin
            classify = TCCC_TERM_OPEN;
        end
    endfunction

    // line above the disconnect threshold of the active pull-up current
    function automatic logic above_disc(input tccc_cc_cmp_s c, input logic hi);
        above_disc = hi ? c.above_disc_high : c.above_disc_default;
    endfunction

    // ======================================================================
    // input synchroniser, two flops for every async input
    // ======================================================================
    localparam int SYNC_W = 2 * $bits(tccc_cc_cmp_s) + 8;
    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_q;
    logic [SYNC_W-1:0] sync_d;
    assign sync_d = {cc_first_i, cc_second_i, bus_present_i, vconn_limit_i,
                     vconn_overtemp_i, rail_uvlo_i, reverse_current_i,
                     regulator_settled_i, sink_role_i, pullup_high_req_i};

    // metastability filter
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sync_meta <= '0;
            sync_q <= '0;
        end else begin
            sync_meta <= sync_d;
            sync_q <= sync_meta;
        end
    end

    tccc_cc_cmp_s cc1;
    tccc_cc_cmp_s cc2;
    logic bus_s, lim_s, ot_s, uvlo_s, rev_s, settled_s, snk_s, hi_req_s;
    assign {cc1, cc2, bus_s, lim_s, ot_s, uvlo_s, rev_s, settled_s, snk_s, hi_req_s} = sync_q;

    tccc_term_e t1;
    tccc_term_e t2;
    assign t1 = classify(cc1);
    assign t2 = classify(cc2);

    // ======================================================================
    // pull-up current and comparator reference
    // ======================================================================
    logic hi_cur;

    // low current until regulator at 5 v, then firmware choice
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hi_cur <= 1'b0;
        end else begin
            hi_cur <= settled_s & hi_req_s & ~snk_s;
        end
    end

    // reference mux for both detectors
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cmp_ref_o <= REF_SRC_LOW;
        end else if (snk_s) begin
            cmp_ref_o <= REF_SNK;
        end else begin
            cmp_ref_o <= hi_cur ? REF_SRC_HIGH : REF_SRC_LOW;
        end
    end

    // ======================================================================
    // source attach state machine with tcc disconnect filter
    // ======================================================================
    tccc_state_e state;
    tccc_state_e next_state;
    logic [TCC_CNT_W-1:0] disc_cnt;
    logic disc_line_hi;
    logic disc_done;
    logic connected;

    assign connected = (state != TCCC_ST_OPEN);
    assign disc_done = (disc_cnt >= TCC_CNT_W'(TCC_CNT));

    // line being watched for detach in each state
    always_comb begin
        case (state)
            TCCC_ST_SNK_1, TCCC_ST_CBL_1, TCCC_ST_FULL_2: begin
                disc_line_hi = above_disc(cc1, hi_cur);
            end
            TCCC_ST_SNK_2, TCCC_ST_CBL_2, TCCC_ST_FULL_1: begin
                disc_line_hi = above_disc(cc2, hi_cur);
            end
            default: begin
                disc_line_hi = 1'b0;
            end
        endcase
    end

    // disconnect filter counter
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            disc_cnt <= '0;
        end else if (!connected || !disc_line_hi || disc_done) begin
            disc_cnt <= '0;
        end else begin
            disc_cnt <= disc_cnt + TCC_CNT_W'(1);
        end
    end

    // next attach state
    always_comb begin
        next_state = state;
        case (state)
            TCCC_ST_OPEN: begin
                if (t1 == TCCC_TERM_RD && t2 == TCCC_TERM_OPEN) begin
                    next_state = TCCC_ST_SNK_1;
                end else if (t1 == TCCC_TERM_OPEN && t2 == TCCC_TERM_RD) begin
                    next_state = TCCC_ST_SNK_2;
                end else if (t1 == TCCC_TERM_RA && t2 == TCCC_TERM_RD) begin
                    next_state = TCCC_ST_FULL_1;
                end else if (t1 == TCCC_TERM_RD && t2 == TCCC_TERM_RA) begin
                    next_state = TCCC_ST_FULL_2;
                end else if (t1 == TCCC_TERM_RA && t2 == TCCC_TERM_OPEN) begin
                    next_state = TCCC_ST_CBL_1;
                end else if (t1 == TCCC_TERM_OPEN && t2 == TCCC_TERM_RA) begin
                    next_state = TCCC_ST_CBL_2;
                end
            end
            TCCC_ST_CBL_1: begin
                if (disc_done) begin
                    next_state = TCCC_ST_OPEN;
                end else if (t2 == TCCC_TERM_RD) begin
                    next_state = TCCC_ST_FULL_1;
                end
            end
            TCCC_ST_CBL_2: begin
                if (disc_done) begin
                    next_state = TCCC_ST_OPEN;
                end else if (t1 == TCCC_TERM_RD) begin
                    next_state = TCCC_ST_FULL_2;
                end
            end
            TCCC_ST_SNK_1, TCCC_ST_SNK_2, TCCC_ST_FULL_1, TCCC_ST_FULL_2: begin
                if (disc_done) begin
                    next_state = TCCC_ST_OPEN;
                end
            end
            default: begin
                next_state = TCCC_ST_OPEN;
            end
        endcase
        if (snk_s) begin
            next_state = TCCC_ST_OPEN;
        end
    end

    // attach state register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state <= TCCC_ST_OPEN;
        end else begin
            state <= next_state;
        end
    end

    // ======================================================================
    // faults: vconn overtemperature, rail undervoltage, cc overvoltage
    // ======================================================================
    logic vconn_kill;
    logic ovp_any;
    assign ovp_any = cc1.ovp | cc2.ovp | rev_s;

    // vconn latched off until detach once overvoltage or overtemperature hits; undervoltage does not latch
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            vconn_kill <= 1'b0;
        end else if (ovp_any || (lim_s && ot_s)) begin
            vconn_kill <= 1'b1;
        end else if (!connected) begin
            vconn_kill <= 1'b0;
        end
    end

    // error recovery flag, set wins over acknowledge
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            error_recovery_o <= 1'b0;
        end else if (lim_s && ot_s) begin
            error_recovery_o <= 1'b1;
        end else if (error_recovery_ack_i) begin
            error_recovery_o <= 1'b0;
        end
    end

    // ======================================================================
    // power and watch outputs decoded from state
    // ======================================================================
    logic vconn_ok;
    assign vconn_ok = ~vconn_kill & ~uvlo_s & ~ovp_any & ~(lim_s & ot_s);

    // registered port controls
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl_o <= '0;
            attach_state_o <= TCCC_ST_OPEN;
        end else begin
            attach_state_o <= state;
            ctrl_o.bus_power_en <= (state == TCCC_ST_SNK_1) || (state == TCCC_ST_SNK_2) ||
                                   (state == TCCC_ST_FULL_1) || (state == TCCC_ST_FULL_2);
            ctrl_o.vconn_first_en <= (state == TCCC_ST_FULL_1) && vconn_ok;
            ctrl_o.vconn_second_en <= (state == TCCC_ST_FULL_2) && vconn_ok;
            ctrl_o.watch_first <= (state == TCCC_ST_OPEN) || (state == TCCC_ST_SNK_1) ||
                                  (state == TCCC_ST_CBL_1) || (state == TCCC_ST_CBL_2) ||
                                  (state == TCCC_ST_FULL_2);
            ctrl_o.watch_second <= (state == TCCC_ST_OPEN) || (state == TCCC_ST_SNK_2) ||
                                   (state == TCCC_ST_CBL_1) || (state == TCCC_ST_CBL_2) ||
                                   (state == TCCC_ST_FULL_1);
            ctrl_o.tx_en <= tx_req_i && !ovp_any && connected;
            ctrl_o.tx_on_second <= (state == TCCC_ST_SNK_2) || (state == TCCC_ST_FULL_1);
        end
    end

    // ======================================================================
    // pd transmitter drive on the mated line, or on the first line in cable-only states
    // ======================================================================
    logic tx_act;
    logic mated_second;
    assign tx_act = tx_req_i & ~ovp_any & connected;
    assign mated_second = (state == TCCC_ST_SNK_2) || (state == TCCC_ST_FULL_1);

    // driver enables: low while driving, else high impedance
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cc_first_out_o <= 1'b0;
            cc_second_out_o <= 1'b0;
            cc_first_oe_n_o <= 1'b1;
            cc_second_oe_n_o <= 1'b1;
        end else begin
            cc_first_out_o <= tx_data_i;
            cc_second_out_o <= tx_data_i;
            cc_first_oe_n_o <= ~(tx_act & ~mated_second);
            cc_second_oe_n_o <= ~(tx_act & mated_second);
        end
    end

    // squelch follows the mated line (the first line in cable-only states) whoever transmits
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            squelch_o <= 1'b0;
        end else begin
            squelch_o <= mated_second ? cc2.squelch : cc1.squelch;
        end
    end

    // ======================================================================
    // sink role
    // ======================================================================
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sink_pulldown_o <= 1'b0;
            sink_attached_o <= 1'b0;
            sink_adv_current_o <= ADV_NONE;
            pullup_high_o <= 1'b0;
        end else begin
            pullup_high_o <= hi_cur;
            sink_pulldown_o <= snk_s;
            sink_attached_o <= snk_s & bus_s;
            if (!(snk_s && bus_s)) begin
                sink_adv_current_o <= ADV_NONE;
            end else if (cc1.snk_high || cc2.snk_high) begin
                sink_adv_current_o <= ADV_HIGH;
            end else if (cc1.snk_low || cc2.snk_low) begin
                sink_adv_current_o <= ADV_LOW;
            end else begin
                sink_adv_current_o <= ADV_DEFAULT;
            end
        end
    end

endmodule

// *** tb/tccc_far_end.sv ***
// far-side model: sink or cable terminations seen by one cc line
`timescale 1ns/10ps
module tccc_far_end
    import tccc_pkg::*;
(
    input wire logic [1:0] lvl_i,
    input wire logic [1:0] adv_i,
    input wire logic ovp_i,
    input wire logic squelch_i,
    output tccc_cc_cmp_s cmp_o
);
    // ====================================================
    // termination to comparator levels
    // lvl_i: 0 open, 1 rd, 2 ra, 3 between the two disconnect levels
    // this end only terminates, it never drives the wire
    always_comb begin
        cmp_o.below_cable_marker = (lvl_i == 2'h2);
        cmp_o.below_attach = (lvl_i == 2'h1) || (lvl_i == 2'h2);
        cmp_o.above_disc_default = (lvl_i == 2'h0) || (lvl_i == 2'h3);
        cmp_o.above_disc_high = (lvl_i == 2'h0);
        cmp_o.snk_high = (adv_i == 2'h3);
        cmp_o.snk_low = adv_i[1];
        cmp_o.ovp = ovp_i;
        cmp_o.squelch = squelch_i;
    end
endmodule

// *** tb/tccc_supervisor_asserts.sv ***
// checker: port assertions of the cc supervisor
`timescale 1ns/10ps
module tccc_sup_chk
    import tccc_pkg::*;
#(
    parameter int TCC_CNT = 20
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic sink_role_i,
    input wire logic regulator_settled_i,
    input wire tccc_cc_cmp_s cc_first_i,
    input wire tccc_cc_cmp_s cc_second_i,
    input wire logic vconn_limit_i,
    input wire logic vconn_overtemp_i,
    input wire logic rail_uvlo_i,
    input wire logic reverse_current_i,
    input wire tccc_state_e attach_state_o,
    input wire tccc_ctrl_s ctrl_o,
    input wire logic pullup_high_o,
    input wire logic [1:0] cmp_ref_o,
    input wire logic sink_pulldown_o,
    input wire logic error_recovery_o,
    input wire logic cc_first_oe_n_o,
    input wire logic cc_second_oe_n_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    logic [23:0] hi1, hi2;
    logic vc;
    assign vc = ctrl_o.vconn_first_en | ctrl_o.vconn_second_en;
    // ====================================================
    // run length of each line above the lower disconnect level
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !cc_first_i.above_disc_default) hi1 <= 24'h00_0000;
        else hi1 <= hi1 + 24'h00_0001;
        if (rst_i || !cc_second_i.above_disc_default) hi2 <= 24'h00_0000;
        else hi2 <= hi2 + 24'h00_0001;
    end
    // ====================================================
    // assertions
    a_unpowered_states: assert property (
        attach_state_o inside {TCCC_ST_OPEN, TCCC_ST_CBL_1, TCCC_ST_CBL_2} |-> ctrl_o[6:4] == 3'h0)
        else $error("power applied without sink");
    a_sink_first: assert property (
        attach_state_o == TCCC_ST_SNK_1 |-> ctrl_o[6:2] == 5'h12) else $error("sink first ctrl");
    a_sink_second: assert property (
        attach_state_o == TCCC_ST_SNK_2 |-> ctrl_o[6:2] == 5'h11) else $error("sink second ctrl");
    a_full_first: assert property (
        attach_state_o == TCCC_ST_FULL_1 |-> {ctrl_o[6], ctrl_o[4:2]} == 4'h9)
        else $error("full first ctrl");
    a_full_second: assert property (
        attach_state_o == TCCC_ST_FULL_2 |-> {ctrl_o[6:5], ctrl_o[3:2]} == 4'ha)
        else $error("full second ctrl");
    a_low_pullup: assert property (
        !regulator_settled_i [*6] |-> !pullup_high_o) else $error("high pull-up unsettled");
    a_detach_filter: assert property (
        $past(attach_state_o) != TCCC_ST_OPEN && attach_state_o == TCCC_ST_OPEN && !sink_role_i
        |-> hi1 >= TCC_CNT || hi2 >= TCC_CNT) else $error("detach before filter time");
    a_sink_ref: assert property (
        sink_role_i [*6] |-> cmp_ref_o == REF_SNK && sink_pulldown_o
        && attach_state_o == TCCC_ST_OPEN) else $error("sink role outputs");
    a_overtemp_off: assert property (
        (vconn_limit_i && vconn_overtemp_i) [*3] |=> !vc && error_recovery_o)
        else $error("overtemp vconn");
    a_uvlo_off: assert property (
        rail_uvlo_i [*3] |=> !vc) else $error("uvlo vconn");
    a_ovp_off: assert property (
        (cc_first_i.ovp || cc_second_i.ovp || reverse_current_i) [*3] |=> !vc
        && cc_first_oe_n_o && cc_second_oe_n_o) else $error("ovp shutdown");
    a_single_driver: assert property (
        cc_first_oe_n_o || cc_second_oe_n_o) else $error("both lines driven");
    // main scenarios reached
    c_full: cover property (attach_state_o == TCCC_ST_FULL_1);
    c_recovery: cover property ($rose(error_recovery_o));
    c_tx: cover property ($fell(cc_second_oe_n_o));
endmodule

bind tccc_supervisor tccc_sup_chk #(.TCC_CNT(TCC_CNT)) i_chk (
    .clk_sys_i, .rst_i, .sink_role_i, .regulator_settled_i, .cc_first_i, .cc_second_i,
    .vconn_limit_i, .vconn_overtemp_i, .rail_uvlo_i, .reverse_current_i, .attach_state_o,
    .ctrl_o, .pullup_high_o, .cmp_ref_o, .sink_pulldown_o, .error_recovery_o,
    .cc_first_oe_n_o, .cc_second_oe_n_o
);

// *** tb/typec_cc_attach_vconn_control_tb_top.sv ***
// testbench: attach, detach, fault and sink cases of the cc supervisor
`timescale 1ns/10ps
module typec_cc_attach_vconn_control_tb_top
    import tccc_pkg::*;
;
    localparam int TCC_SIM = 20;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, sink_role_i = 1'b0, pullup_high_req_i = 1'b1;
    logic regulator_settled_i = 1'b0, bus_present_i = 1'b0, vconn_limit_i = 1'b0;
    logic vconn_overtemp_i = 1'b0, rail_uvlo_i = 1'b0, reverse_current_i = 1'b0;
    logic tx_req_i = 1'b0, tx_data_i = 1'b0, error_recovery_ack_i = 1'b0;
    logic ovp1 = 1'b0, ovp2 = 1'b0, sq1 = 1'b0, sq2 = 1'b0;
    logic [1:0] l1 = 2'h0, l2 = 2'h0, adv = 2'h0, vc;
    tccc_cc_cmp_s cc_first_i, cc_second_i;
    tccc_state_e attach_state_o;
    tccc_ctrl_s ctrl_o;
    logic pullup_high_o, sink_pulldown_o, sink_attached_o, error_recovery_o, squelch_o;
    logic cc_first_out_o, cc_first_oe_n_o, cc_second_out_o, cc_second_oe_n_o;
    logic [1:0] cmp_ref_o, sink_adv_current_o;
    int mismatches = 0, checks_done = 0, seed = 11;
    assign vc = {ctrl_o.vconn_first_en, ctrl_o.vconn_second_en};

    // ====================================================
    // clock, device and far-side models
    always #2 clk_sys_i = ~clk_sys_i;
    tccc_supervisor #(.TCC_CNT(TCC_SIM)) i_dut (
        .clk_sys_i, .rst_i, .sink_role_i, .pullup_high_req_i, .regulator_settled_i,
        .bus_present_i, .cc_first_i, .cc_second_i, .vconn_limit_i, .vconn_overtemp_i,
        .rail_uvlo_i, .reverse_current_i, .tx_req_i, .tx_data_i, .error_recovery_ack_i,
        .attach_state_o, .ctrl_o, .pullup_high_o, .cmp_ref_o, .sink_pulldown_o,
        .sink_attached_o, .sink_adv_current_o, .error_recovery_o, .squelch_o,
        .cc_first_out_o, .cc_first_oe_n_o, .cc_second_out_o, .cc_second_oe_n_o
    );
    tccc_far_end i_far_first (.lvl_i(l1), .adv_i(adv), .ovp_i(ovp1), .squelch_i(sq1),
        .cmp_o(cc_first_i));
    tccc_far_end i_far_second (.lvl_i(l2), .adv_i(adv), .ovp_i(ovp2), .squelch_i(sq2),
        .cmp_o(cc_second_i));

    // ====================================================
    // expectations, compares and timing helpers
    function automatic tccc_state_e exp_st(input logic [1:0] a, input logic [1:0] b);
        case ({a, b})
            4'h4: exp_st = TCCC_ST_SNK_1;
            4'h1: exp_st = TCCC_ST_SNK_2;
            4'h8: exp_st = TCCC_ST_CBL_1;
            4'h2: exp_st = TCCC_ST_CBL_2;
            4'h9: exp_st = TCCC_ST_FULL_1;
            4'h6: exp_st = TCCC_ST_FULL_2;
            default: exp_st = TCCC_ST_OPEN; // open pair and double rd or ra stay idle
        endcase
    endfunction
    // {bus power, vconn first, vconn second, watch first, watch second}
    function automatic logic [4:0] exp_ctl(input tccc_state_e st);
        case (st)
            TCCC_ST_SNK_1: exp_ctl = 5'h12;
            TCCC_ST_SNK_2: exp_ctl = 5'h11;
            TCCC_ST_FULL_1: exp_ctl = 5'h19;
            TCCC_ST_FULL_2: exp_ctl = 5'h16;
            default: exp_ctl = 5'h03;
        endcase
    endfunction
    task automatic chk_state(input string what, input tccc_state_e exp, input tccc_state_e got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bits(input string what, input logic [6:0] exp, input logic [6:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // wait n rising edges, then sample at the falling edge
    task automatic go(input int n);
        repeat (n) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask
    task automatic lines(input logic [1:0] a, input logic [1:0] b, input int n);
        @(posedge clk_sys_i);
        l1 <= a;
        l2 <= b;
        go(n);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ====================================================
    // main sequence
    initial begin
        logic [1:0] a, b;
        tccc_state_e st;
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        go(6);
        chk_state("reset state", TCCC_ST_OPEN, attach_state_o);
        chk_bits("pull-up unsettled", 7'h00, {4'h0, pullup_high_o, cmp_ref_o});
        // every termination pair, then random ones, each closed by a detach
        for (int i = 0; i < 29; i++) begin
            a = (i < 9) ? 2'(i / 3) : 2'($unsigned($random(seed)) % 3);
            b = (i < 9) ? 2'(i % 3) : 2'($unsigned($random(seed)) % 3);
            st = exp_st(a, b);
            lines(a, b, 6);
            chk_state("attach", st, attach_state_o);
            chk_bits("ctrl", {2'h0, exp_ctl(st)}, {2'h0, ctrl_o[6:2]});
            lines(2'h0, 2'h0, TCC_SIM + 8);
            chk_state("detach", TCCC_ST_OPEN, attach_state_o);
        end
        // a short open is filtered; a level above the lower threshold detaches
        lines(2'h1, 2'h0, 6);
        lines(2'h0, 2'h0, TCC_SIM / 2);
        lines(2'h1, 2'h0, 6);
        chk_state("bounce", TCCC_ST_SNK_1, attach_state_o);
        lines(2'h3, 2'h0, TCC_SIM + 8);
        chk_state("low level detach", TCCC_ST_OPEN, attach_state_o);
        // settled regulator allows the high pull-up and the higher threshold
        @(posedge clk_sys_i);
        regulator_settled_i <= 1'b1;
        lines(2'h1, 2'h0, 6);
        chk_bits("pull-up high", 7'h05, {4'h0, pullup_high_o, cmp_ref_o});
        lines(2'h3, 2'h0, TCC_SIM + 8);
        chk_state("high level kept", TCCC_ST_SNK_1, attach_state_o);
        // firmware withdraws the high pull-up request one cycle before a detach
        @(posedge clk_sys_i);
        pullup_high_req_i <= 1'b0;
        lines(2'h0, 2'h0, TCC_SIM + 8);
        chk_bits("pull-up kept low", 7'h00, {4'h0, pullup_high_o, cmp_ref_o});
        chk_state("high level detach", TCCC_ST_OPEN, attach_state_o);
        // cable first, then a sink on the other line; then vconn faults
        lines(2'h2, 2'h0, 6);
        lines(2'h2, 2'h1, 6);
        chk_state("cable then sink", TCCC_ST_FULL_1, attach_state_o);
        @(posedge clk_sys_i);
        rail_uvlo_i <= 1'b1;
        go(4);
        chk_bits("uvlo", 7'h00, {5'h00, vc});
        @(posedge clk_sys_i);
        rail_uvlo_i <= 1'b0;
        go(5);
        chk_bits("uvlo release", 7'h02, {5'h00, vc});
        @(posedge clk_sys_i);
        vconn_limit_i <= 1'b1;
        vconn_overtemp_i <= 1'b1;
        go(4);
        @(posedge clk_sys_i);
        vconn_overtemp_i <= 1'b0;
        go(4);
        chk_bits("overtemp latch", 7'h01, {4'h0, vc, error_recovery_o});
        @(posedge clk_sys_i);
        error_recovery_ack_i <= 1'b1;
        @(posedge clk_sys_i);
        error_recovery_ack_i <= 1'b0;
        vconn_limit_i <= 1'b0;
        go(2);
        chk_bits("recovery ack", 7'h00, {4'h0, vc, error_recovery_o});
        lines(2'h0, 2'h0, TCC_SIM + 8);
        // transmit and squelch on the mated line, then overvoltage
        lines(2'h2, 2'h1, 6);
        @(posedge clk_sys_i);
        tx_req_i <= 1'b1;
        tx_data_i <= 1'b1;
        sq2 <= 1'b1;
        go(4);
        chk_bits("tx", 7'h77, {ctrl_o[1:0], cc_first_oe_n_o, cc_second_oe_n_o, cc_first_out_o,
            cc_second_out_o, squelch_o});
        @(posedge clk_sys_i);
        ovp2 <= 1'b1;
        go(4);
        chk_bits("ovp", 7'h1c, {1'h0, ctrl_o[1:0], cc_first_oe_n_o, cc_second_oe_n_o,
            vc});
        @(posedge clk_sys_i);
        ovp2 <= 1'b0;
        tx_req_i <= 1'b0;
        sq2 <= 1'b0;
        lines(2'h0, 2'h0, TCC_SIM + 8);
        // sink role with each advertised current
        @(posedge clk_sys_i);
        sink_role_i <= 1'b1;
        bus_present_i <= 1'b1;
        for (int k = 1; k < 4; k++) begin
            @(posedge clk_sys_i);
            adv <= 2'(k);
            go(6);
            chk_bits("sink", {1'b0, 4'he, 2'(k)}, {1'b0, sink_pulldown_o, sink_attached_o,
                cmp_ref_o, sink_adv_current_o});
        end
        give_verdict();
    end

    // cut a hang short
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches++;
        give_verdict();
    end
endmodule
